// File: hw/usbtep_ctrl.sv
// control and status logic for one transmit endpoint
`timescale 1ns/1ps
`default_nettype none
module usbtep_ctrl
    import usbtep_pkg::*;
#(
    parameter int MPS_W = 11  // width of the packet size field
)
(
    // clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // configuration from neighbouring registers
    input wire logic host_role,
    input wire logic [MPS_W-1:0] tx_max_packet_size,
    input wire logic [4:0] tx_poll_interval,
    // fifo load side
    input wire logic fifo_byte_loaded,
    // usb engine events
    input wire logic in_token,
    input wire logic packet_acked,
    input wire logic no_handshake,
    input wire logic stall_seen,
    input wire logic nak_seen,
    input wire logic frame_tick,
    // to the engine and fifo
    output logic tx_packet_ready,
    output logic stall_response,
    output logic data_toggle,
    output logic endpoint_halted,
    output logic fifo_ptr_reset,
    output logic packet_discard,
    output logic sent_event,
    output logic error_event
);
    // ==========================================================
    // state
    typedef struct packed {
        logic ack;                // bus answer
        logic [15:0] rdat;        // read data
        logic ready;              // tx_packet_ready
        logic underrun;           // peripheral underrun flag
        logic stall_request;      // peripheral stall request
        logic stall_sent_flag;    // peripheral stall sent
        logic stall_received_flag;// host stall received
        logic error;              // host error flag
        logic nak_expiry_flag;    // host nak timeout
        logic iso;                // transfer type
        logic auto_ready;         // auto_ready_on_full_packet
        logic spare;              // spare bit 13
        logic toggle;             // data toggle
        logic [1:0] pkts;         // packets held in fifo
        logic [MPS_W-1:0] bytes;  // bytes of packet being loaded
        logic second_full;        // buffered packet is full size
        logic [1:0] tries;        // unanswered attempts
        logic ptr_rst;            // pointer reset pulse
        logic discard;            // discard pulse
        logic sent;               // sent pulse
        logic err_ev;             // error pulse
    } usbtep_state_s;
    usbtep_state_s q, d;             // registered state and its next value
    logic nak_fire, bus_req, wr_csr; // timer pulse, request, csr write
    logic [31:0] wdat;
    // ==========================================================
    // helpers
    // image of the control word in the current layout
    function automatic logic [15:0] csr_image(input usbtep_state_s s,
                                              input logic host);
        logic [15:0] v;
        v = '0;
        v[USBTEP_B_READY] = s.ready;
        v[USBTEP_B_HASPKT] = (s.pkts != 2'h0);
        v[USBTEP_B_ISO] = s.iso;
        v[USBTEP_B_AUTO] = s.auto_ready;
        v[USBTEP_B_SPARE] = s.spare;
        if (host) begin
            v[USBTEP_H_ERR] = s.error;
            v[USBTEP_H_STLRCV] = s.stall_received_flag;
            v[USBTEP_H_NAK] = s.nak_expiry_flag;
        end else begin
            v[USBTEP_P_UNDER] = s.underrun;
            v[USBTEP_P_STLREQ] = s.stall_request;
            v[USBTEP_P_STLSNT] = s.stall_sent_flag;
        end
        return v;
    endfunction : csr_image
    // one packet fewer, never below zero
    function automatic logic [1:0] dec_pkts(input logic [1:0] n);
        return (n == 2'h0) ? 2'h0 : n - 2'h1;
    endfunction : dec_pkts
    // ==========================================================
    // outputs
    assign bus_req = wb_cyc_i && wb_stb_i;
    assign wr_csr = bus_req && wb_we_i && q.ack && wb_adr_i == USBTEP_ADR_CSR;
    assign wdat = wb_dat_i;
    assign wb_ack_o = q.ack;
    assign wb_dat_o = {16'h0000, q.rdat};
    assign tx_packet_ready = q.ready;
    assign stall_response = !host_role && q.stall_request && !q.iso;
    assign data_toggle = q.toggle;
    assign endpoint_halted = host_role && q.nak_expiry_flag;
    assign fifo_ptr_reset = q.ptr_rst;
    assign packet_discard = q.discard;
    assign sent_event = q.sent;
    assign error_event = q.err_ev;
    // ==========================================================
    // nak run timer, bulk endpoints in host role
    usbtep_nak_timer u_nak (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .clear(packet_acked || q.nak_expiry_flag),
        .enable(host_role && !q.iso),
        .nak_limit(tx_poll_interval),
        .nak_seen(nak_seen),
        .frame_tick(frame_tick),
        .expired(nak_fire)
    );
    // ==========================================================
    // next state: software first, hardware events after so they win
    always_comb begin
        d = q;
        d.ptr_rst = 1'b0;
        d.discard = 1'b0;
        d.sent = 1'b0;
        d.err_ev = 1'b0;
        // bus answer one cycle after request, dropped after
        d.ack = bus_req && !q.ack;
        if (bus_req && !q.ack) begin
            // unmapped addresses read as zero
            d.rdat = '0;
            if (wb_adr_i == USBTEP_ADR_CSR) begin
                d.rdat = csr_image(q, host_role);
            end else if (wb_adr_i == USBTEP_ADR_INFO) begin
                // toggle, packets held, halted
                d.rdat = {12'h000, endpoint_halted, q.pkts, q.toggle};
            end
        end
        // upper byte of the control word
        if (wr_csr && wb_sel_i[1]) begin
            d.auto_ready = wdat[USBTEP_B_AUTO];
            d.iso = wdat[USBTEP_B_ISO];
            d.spare = wdat[USBTEP_B_SPARE];
            if (wdat[USBTEP_B_TGLFRC]) begin
                d.toggle = !q.toggle;
                d.ready = 1'b0;
                d.pkts = dec_pkts(q.pkts);
                d.discard = 1'b1;
            end
        end
        // lower byte of the control word
        if (wr_csr && wb_sel_i[0]) begin
            if (wdat[USBTEP_B_READY]) begin
                d.ready = 1'b1;
                if (q.pkts != USBTEP_MAX_PKTS) begin
                    d.pkts = q.pkts + 2'h1;
                end
                d.bytes = '0;
            end
            if (wdat[USBTEP_B_PURGE] && q.ready) begin
                d.ptr_rst = 1'b1;
                // a second buffered packet stays ready for the next purge
                d.ready = (q.pkts > 2'h1);
                d.pkts = dec_pkts(q.pkts);
                d.bytes = '0;
                d.second_full = 1'b0;
            end
            if (wdat[USBTEP_B_TGLRST]) begin
                d.toggle = 1'b0;
            end
            // sticky flags: a zero clears, a one keeps; stall_request takes the written bit
            if (host_role) begin
                d.error &= wdat[USBTEP_H_ERR];
                d.stall_received_flag &= wdat[USBTEP_H_STLRCV];
                d.nak_expiry_flag &= wdat[USBTEP_H_NAK];
            end else begin
                d.stall_request = wdat[USBTEP_P_STLREQ];
                d.underrun &= wdat[USBTEP_P_UNDER];
                d.stall_sent_flag &= wdat[USBTEP_P_STLSNT];
            end
        end
        // byte loaded into the fifo
        if (fifo_byte_loaded) begin
            d.bytes = q.bytes + {{(MPS_W-1){1'b0}}, 1'b1};
            if (q.auto_ready && d.bytes == tx_max_packet_size) begin
                d.bytes = '0;
                if (q.ready) begin
                    d.second_full = 1'b1;
                end
                d.ready = 1'b1;
                if (q.pkts != USBTEP_MAX_PKTS) begin
                    d.pkts = q.pkts + 2'h1;
                end
            end
        end
        // peripheral role: IN token
        if (!host_role && in_token) begin
            if (stall_response) begin
                d.stall_sent_flag = 1'b1;
                d.ptr_rst = 1'b1;
                d.ready = 1'b0;
                d.pkts = 2'h0;
                d.second_full = 1'b0;
            end else if (!q.ready) begin
                d.underrun = 1'b1;
            end
        end
        // packet acknowledged
        if (packet_acked) begin
            d.ready = 1'b0;
            d.toggle = !q.toggle;
            d.pkts = dec_pkts(q.pkts);
            d.tries = 2'h0;
            d.sent = 1'b1;
            d.second_full = 1'b0;
            // full second packet goes at once
            if (q.auto_ready && q.second_full && q.pkts > 2'h1) begin
                d.ready = 1'b1;
            end
        end
        // host role events
        if (host_role) begin
            if (no_handshake && !q.iso) begin
                d.tries = q.tries + 2'h1;
                if (q.tries + 2'h1 == USBTEP_MAX_TRIES) begin
                    d.error = 1'b1;
                    d.err_ev = 1'b1;
                    d.tries = 2'h0;
                end
            end
            if (stall_seen) begin
                d.stall_received_flag = 1'b1;
                d.ptr_rst = 1'b1;
                d.ready = 1'b0;
                d.pkts = 2'h0;
                d.second_full = 1'b0;
                d.tries = 2'h0;
            end
            if (nak_fire) begin
                d.nak_expiry_flag = 1'b1;
            end
        end
    end
    // state register
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            q <= '0;
            q.spare <= USBTEP_CSR_RST[USBTEP_B_SPARE];
        end else begin
            q <= d;
        end
    end
    // ==========================================================
    // checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    sequence s_bus_hold;
        bus_req && !q.ack;
    endsequence
    property p_wb_ack;
        s_bus_hold |=> q.ack ##1 !q.ack;
    endproperty
    a_wb_ack: assert property (p_wb_ack) else $error("ack not one cycle");
    property p_underrun;
        !host_role && in_token && !q.ready && !stall_response |=> q.underrun;
    endproperty
    a_underrun: assert property (p_underrun)
        else $error("underrun not set");
    sequence s_stall_out;
        !host_role && in_token && stall_response;
    endsequence
    property p_stall_sent;
        s_stall_out |=> q.stall_sent_flag && q.ptr_rst && q.pkts == 2'h0;
    endproperty
    a_stall_sent: assert property (p_stall_sent)
        else $error("stall sent not handled");
    property p_purge;
        wr_csr && wb_sel_i[0] && wdat[USBTEP_B_PURGE] && q.ready
            |=> q.ptr_rst ##1 !q.ptr_rst;
    endproperty
    a_purge: assert property (p_purge)
        else $error("purge pulse wrong");
    property p_purge_idle;
        !q.ready && !in_token && !stall_seen |=> !q.ptr_rst;
    endproperty
    a_purge_idle: assert property (p_purge_idle)
        else $error("pointer reset without ready");
    property p_toggle_force;
        wr_csr && wb_sel_i[1] && wdat[USBTEP_B_TGLFRC] && !packet_acked
            && !(wb_sel_i[0] && wdat[USBTEP_B_TGLRST])
            |=> q.toggle != $past(q.toggle) && q.discard;
    endproperty
    a_toggle_force: assert property (p_toggle_force)
        else $error("toggle force failed");
    property p_toggle_reset;
        wr_csr && wb_sel_i[0] && wdat[USBTEP_B_TGLRST] && !packet_acked
            |=> !q.toggle;
    endproperty
    a_toggle_reset: assert property (p_toggle_reset)
        else $error("toggle not cleared");
    property p_error;
        host_role && no_handshake && !q.iso && q.tries == 2'h2
            |=> q.error && q.err_ev;
    endproperty
    a_error: assert property (p_error)
        else $error("error flag missing");
    property p_stall_rcv;
        host_role && stall_seen |=> q.stall_received_flag && !q.ready;
    endproperty
    a_stall_rcv: assert property (p_stall_rcv)
        else $error("received stall not handled");
    property p_auto;
        q.auto_ready && fifo_byte_loaded
            && q.bytes + {{(MPS_W-1){1'b0}}, 1'b1} == tx_max_packet_size
            && !packet_acked && !in_token && !stall_seen
            && !(wr_csr && (wb_sel_i[0] || wb_sel_i[1]))
            |=> q.ready;
    endproperty
    a_auto: assert property (p_auto)
        else $error("auto ready missing");
endmodule : usbtep_ctrl
`default_nettype wire

// File: hw/usbtep_pkg.sv
// shared constants for the transmit endpoint control block
package usbtep_pkg;

    // ==========================================================
    // register map (byte addresses)
    localparam logic [3:0] USBTEP_ADR_CSR = 4'h0;  // control/status word
    localparam logic [3:0] USBTEP_ADR_INFO = 4'h4; // read-only state view

    // ==========================================================
    // control/status reset value
    localparam logic [15:0] USBTEP_CSR_RST = 16'h2000;

    // ==========================================================
    // shared bit positions, both roles
    localparam int USBTEP_B_READY = 0;   // tx_packet_ready
    localparam int USBTEP_B_HASPKT = 1;  // fifo_has_packet
    localparam int USBTEP_B_PURGE = 3;   // fifo_purge
    localparam int USBTEP_B_TGLRST = 6;  // toggle_reset
    localparam int USBTEP_B_TGLFRC = 11; // toggle_force
    localparam int USBTEP_B_SPARE = 13;  // spare bit, resets to one
    localparam int USBTEP_B_ISO = 14;    // transfer type
    localparam int USBTEP_B_AUTO = 15;   // auto_ready_on_full_packet

    // peripheral-role bit positions
    localparam int USBTEP_P_UNDER = 2;   // underrun flag
    localparam int USBTEP_P_STLREQ = 4;  // stall_request
    localparam int USBTEP_P_STLSNT = 5;  // stall_sent_flag

    // host-role bit positions
    localparam int USBTEP_H_ERR = 2;     // no-handshake error flag
    localparam int USBTEP_H_STLRCV = 5;  // stall_received_flag
    localparam int USBTEP_H_NAK = 7;     // nak_expiry_flag

    // ==========================================================
    // counts
    localparam logic [1:0] USBTEP_MAX_TRIES = 2'h3; // attempts before error
    localparam logic [1:0] USBTEP_MAX_PKTS = 2'h2;  // double buffered
    localparam logic [4:0] USBTEP_NAK_MIN = 5'h02;  // smallest live limit

endpackage : usbtep_pkg

// File: hw/usbtep_nak_timer.sv
// frame counter that flags a run of NAK answers past the limit
`timescale 1ns/1ps
`default_nettype none
module usbtep_nak_timer
    import usbtep_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // control
    input wire logic clear,
    input wire logic enable,
    input wire logic [4:0] nak_limit,
    // events
    input wire logic nak_seen,
    input wire logic frame_tick,
    output logic expired
);

    // ==========================================================
    // state
    typedef struct packed {
        logic armed;          // a nak arrived in this frame
        logic [16:0] frames;  // frames with naks so far
        logic fire;           // one-cycle expiry pulse
    } usbtep_nak_s;

    usbtep_nak_s q;
    usbtep_nak_s d;
    logic [16:0] limit_frames;

    // limit of 2^(m-1) frames
    assign limit_frames = 17'h00001 << (nak_limit - 5'h01);
    assign expired = q.fire;

    // next state
    always_comb begin
        d = q;
        d.fire = 1'b0;
        if (clear || !enable || nak_limit < USBTEP_NAK_MIN) begin
            // a good answer or a disabled limit restarts the run
            d = '0;
        end else begin
            if (nak_seen) begin
                d.armed = 1'b1;
            end
            if (frame_tick && q.armed) begin
                d.armed = 1'b0;
                d.frames = q.frames + 17'h00001;
                if (q.frames + 17'h00001 > limit_frames) begin
                    d.fire = 1'b1;
                    d.frames = '0;
                end
            end
        end
    end

    // state register
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

endmodule : usbtep_nak_timer
`default_nettype wire

// File: sim/usbtep_far_end.sv
// behavioural far-side model that pulses the usb engine events
`timescale 1ns/1ps
`default_nettype none
module usbtep_far_end (
    // clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // command from the bench
    input wire logic go,
    input wire logic [2:0] kind,
    // engine events, one cycle each
    output logic in_token,
    output logic packet_acked,
    output logic no_handshake,
    output logic stall_seen,
    output logic nak_seen,
    output logic frame_tick
);
    // ==========================================================
    // one registered pulse per command, nothing between commands
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            in_token <= 1'b0;
            packet_acked <= 1'b0;
            no_handshake <= 1'b0;
            stall_seen <= 1'b0;
            nak_seen <= 1'b0;
            frame_tick <= 1'b0;
        end else begin
            in_token <= go && (kind == 3'h0);
            packet_acked <= go && (kind == 3'h1);
            no_handshake <= go && (kind == 3'h2);
            stall_seen <= go && (kind == 3'h3);
            nak_seen <= go && (kind == 3'h4);
            frame_tick <= go && (kind == 3'h5);
        end
    end
endmodule : usbtep_far_end
`default_nettype wire

// File: sim/testbench.sv
// self-checking bench for the transmit endpoint control block
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import usbtep_pkg::*;
    // ==========================================================
    // bench state and wires
    logic core_clk = 1'b0;
    logic reset_n = 1'b0;
    int errors = 0;
    int check_count = 0;
    integer seed = 32'h19C57F65;
    logic wb_cyc = 1'b0;
    logic wb_stb = 1'b0;
    logic wb_we = 1'b0;
    logic [3:0] wb_adr = 4'h0;
    logic [31:0] wb_wdat = 32'h00000000;
    logic [31:0] wb_rdat;
    logic wb_ack;
    logic host_role = 1'b0;
    logic [10:0] mps = 11'h008;
    logic [4:0] poll = 5'h00;
    logic byte_ld = 1'b0;
    logic go = 1'b0;
    logic [2:0] kind = 3'h0;
    logic in_tok, acked, no_hs, stall_in, nak_in, tick;
    logic tx_ready, stall_resp, data_toggle, halted;
    logic ptr_rst, discard, sent_ev, err_ev;
    int ptr_cnt = 0;
    int err_cnt = 0;
    int sent_cnt = 0;
    int dis_cnt = 0;
    int n;
    logic [15:0] rd;
    logic t0;

    // 100 MHz clock
    always #5 core_clk = ~core_clk;

    // count pointer-reset, error, sent and discard pulses
    always @(posedge core_clk) begin
        if (ptr_rst === 1'b1) ptr_cnt <= ptr_cnt + 1;
        if (err_ev === 1'b1) err_cnt <= err_cnt + 1;
        if (sent_ev === 1'b1) sent_cnt <= sent_cnt + 1;
        if (discard === 1'b1) dis_cnt <= dis_cnt + 1;
    end

    // ==========================================================
    // design and far-side model
    usbtep_ctrl #(.MPS_W(11)) i_dut (
        .core_clk(core_clk), .reset_n(reset_n),
        .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
        .wb_adr_i(wb_adr), .wb_sel_i(4'h3), .wb_dat_i(wb_wdat),
        .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack),
        .host_role(host_role), .tx_max_packet_size(mps),
        .tx_poll_interval(poll), .fifo_byte_loaded(byte_ld),
        .in_token(in_tok), .packet_acked(acked),
        .no_handshake(no_hs), .stall_seen(stall_in),
        .nak_seen(nak_in), .frame_tick(tick),
        .tx_packet_ready(tx_ready), .stall_response(stall_resp),
        .data_toggle(data_toggle), .endpoint_halted(halted),
        .fifo_ptr_reset(ptr_rst), .packet_discard(discard),
        .sent_event(sent_ev), .error_event(err_ev)
    );
    usbtep_far_end i_far (
        .core_clk(core_clk), .reset_n(reset_n), .go(go), .kind(kind),
        .in_token(in_tok), .packet_acked(acked),
        .no_handshake(no_hs), .stall_seen(stall_in),
        .nak_seen(nak_in), .frame_tick(tick)
    );

    // ==========================================================
    // shared tasks
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // one classic wishbone cycle, held until ack is sampled
    task automatic wb_xfer(input logic we, input logic [3:0] adr,
                           input logic [15:0] wd, output logic [15:0] rv);
        int w;
        w = 0;
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= adr;
        wb_wdat <= {16'h0000, wd};
        @(posedge core_clk);
        while (wb_ack !== 1'b1 && w < 16) begin
            @(posedge core_clk);
            w++;
        end
        if (w >= 16) errors++;
        rv = wb_rdat[15:0];
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we <= 1'b0;
        @(posedge core_clk);
    endtask : wb_xfer

    task automatic wr(input logic [15:0] v);
        wb_xfer(1'b1, USBTEP_ADR_CSR, v, rd);
    endtask : wr

    // read the control word and compare one bit
    task automatic rdb(input int b, input logic exp);
        wb_xfer(1'b0, USBTEP_ADR_CSR, 16'h0000, rd);
        check(16'(rd[b]), 16'(exp));
    endtask : rdb

    // ask the far side for one event, then let it land
    task automatic ev(input logic [2:0] k);
        go <= 1'b1;
        kind <= k;
        @(posedge core_clk);
        go <= 1'b0;
        repeat (2) @(posedge core_clk);
    endtask : ev

    task automatic load(input int cnt);
        repeat (cnt) begin
            byte_ld <= 1'b1;
            @(posedge core_clk);
        end
        byte_ld <= 1'b0;
        repeat (2) @(posedge core_clk);
    endtask : load

    task automatic give_verdict;
        if (errors == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : give_verdict

    // watchdog far beyond the expected run
    initial begin
        #200000;
        errors++;
        give_verdict();
    end

    // ==========================================================
    // main sequence
    initial begin
        repeat (10) @(posedge core_clk);
        reset_n <= 1'b1;
        mps <= 11'(8 << ($unsigned($random(seed)) % 4));
        @(posedge core_clk);
        wb_xfer(1'b0, USBTEP_ADR_CSR, 16'h0000, rd);
        check(rd, 16'h2000);
        wb_xfer(1'b0, 4'h8, 16'h0000, rd);
        check(rd, 16'h0000);
        // auto ready: one byte short, then the full packet
        wr(16'hA000);
        load(int'(mps) - 1);
        rdb(0, 1'b0);
        load(1);
        check(16'(tx_ready), 16'h0001);
        rdb(0, 1'b1);
        rdb(1, 1'b1);
        ev(3'h1);
        rdb(0, 1'b0);
        rdb(1, 1'b0);
        check(16'(sent_cnt), 16'h0001);
        // underrun is sticky until written with zero
        wr(16'h2000);
        ev(3'h0);
        rdb(2, 1'b1);
        wr(16'h2004);
        rdb(2, 1'b1);
        wr(16'h2000);
        rdb(2, 1'b0);
        // purge without ready, then with ready
        n = ptr_cnt;
        wr(16'h2008);
        rdb(0, 1'b0);
        check(16'(ptr_cnt - n), 16'h0000);
        load(4);
        wr(16'h2001);
        wr(16'h2009);
        rdb(0, 1'b0);
        check(16'(ptr_cnt - n), 16'h0001);
        rdb(3, 1'b0);
        // stall request answered on the next IN token
        wr(16'h2011);
        check(16'(stall_resp), 16'h0001);
        ev(3'h0);
        rdb(5, 1'b1);
        rdb(0, 1'b0);
        wr(16'h6010);
        check(16'(stall_resp), 16'h0000);
        wr(16'h2000);
        check(16'(stall_resp), 16'h0000);
        // forced flip, then reset of the data toggle
        t0 = data_toggle;
        wr(16'h2800);
        @(posedge core_clk);
        check(16'(data_toggle), 16'(!t0));
        check(16'(dis_cnt), 16'h0001);
        wr(16'h2800);
        check(16'(data_toggle), 16'(t0));
        wr(16'h2040);
        @(posedge core_clk);
        check(16'(data_toggle), 16'h0000);
        // two full packets in auto mode, each acknowledged
        wr(16'hA000);
        load(2 * int'(mps));
        ev(3'h1);
        rdb(0, 1'b1);
        ev(3'h1);
        rdb(0, 1'b0);
        // double buffered fifo needs two purges
        load(2 * int'(mps));
        wr(16'hA008);
        rdb(1, 1'b1);
        wr(16'hA008);
        rdb(1, 1'b0);
        // leave underrun set so the host layout must hide it
        wr(16'h2000);
        ev(3'h0);
        // host role: peripheral events ignored
        host_role <= 1'b1;
        ev(3'h0);
        rdb(2, 1'b0);
        ev(3'h2);
        ev(3'h2);
        rdb(2, 1'b0);
        ev(3'h2);
        rdb(2, 1'b1);
        check(16'(err_cnt), 16'h0001);
        // received stall
        wr(16'h2001);
        n = ptr_cnt;
        ev(3'h3);
        rdb(5, 1'b1);
        rdb(0, 1'b0);
        check(16'(ptr_cnt - n), 16'h0001);
        // nak run over a two-frame limit
        poll <= 5'h02;
        wr(16'h2000);
        for (int i = 1; i <= 3; i++) begin
            ev(3'h4);
            ev(3'h5);
            repeat (3) @(posedge core_clk);
            check(16'(halted), 16'(i == 3));
        end
        rdb(7, 1'b1);
        wb_xfer(1'b0, USBTEP_ADR_INFO, 16'h0000, rd);
        check(rd, 16'h0008);
        wr(16'h2000);
        check(16'(halted), 16'h0000);
        give_verdict();
    end
endmodule : testbench
`default_nettype wire
